// *** pkg/rtcc_defines.vh ***
// Register map, field masks and counting constants of the calendar block
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH

// Byte offsets on the register bus, one 32-bit word each
`define RTCC_OFF_MINUTE 8'h00
`define RTCC_OFF_HOUR 8'h04
`define RTCC_OFF_WEEKDAY 8'h08
`define RTCC_OFF_MDAY 8'h0c
`define RTCC_OFF_MONTH 8'h10
`define RTCC_OFF_PAGE 8'h14
`define RTCC_OFF_CTRL 8'h18

// Implemented bits of each byte register
`define RTCC_MASK_MINUTE 8'h7f
`define RTCC_MASK_HOUR 8'h3f
`define RTCC_MASK_HOUR12 8'h1f
`define RTCC_MASK_WEEKDAY 8'h07
`define RTCC_MASK_MDAY 8'h3f
`define RTCC_MASK_MONTH 8'h1f
`define RTCC_MASK_FORMAT 8'h01
`define RTCC_MASK_PAGE 8'h01
`define RTCC_MASK_CTRL 8'h03

// Field positions
`define RTCC_BIT_PAGE 0
`define RTCC_BIT_FORMAT 0
`define RTCC_BIT_PM 5
`define RTCC_BIT_RUN 0
`define RTCC_BIT_LEAP 1

// Reset values of the byte registers and the page select
`define RTCC_RST_BYTE 8'h00
`define RTCC_RST_PAGE 1'b0

// BCD limits of the counters
`define RTCC_BCD_ZERO 8'h00
`define RTCC_BCD_ONE 8'h01
`define RTCC_BCD_NINE 4'h9
`define RTCC_MIN_LAST 8'h59
`define RTCC_H24_LAST 8'h23
`define RTCC_H12_LAST 8'h11
`define RTCC_WDAY_LAST 8'h06
`define RTCC_MONTH_LAST 8'h12
`define RTCC_FEB 8'h02
`define RTCC_APR 8'h04
`define RTCC_JUN 8'h06
`define RTCC_SEP 8'h09
`define RTCC_NOV 8'h11
`define RTCC_DAYS_28 8'h28
`define RTCC_DAYS_29 8'h29
`define RTCC_DAYS_30 8'h30
`define RTCC_DAYS_31 8'h31

// Timing: one minute of counting at the system clock rate
`define RTCC_MINUTE_S 60
`define RTCC_CLOCK_HZ 10000000

`endif

// *** verilog/rtcc_regs.v ***
// Calendar and time-of-day registers with two-page access over Wishbone
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_defines.vh"

module rtcc_regs #(
    parameter MINUTE_CYCLES = `RTCC_MINUTE_S * `RTCC_CLOCK_HZ,
    parameter PRESCALE_W = 30
) (
    input wire clock,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o
);

    // BCD step with wrap from last back to first
    function [7:0] bcd_inc;
        input [7:0] v;
        input [7:0] last;
        input [7:0] first;
        begin
            if (v == last) begin
                bcd_inc = first;
            end else if (v[3:0] == `RTCC_BCD_NINE) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = v + 8'h01;
            end
        end
    endfunction

    // Last day of a month in BCD; February length taken from leap bit
    function [7:0] month_len;
        input [7:0] month;
        input leap;
        begin
            case (month)
                `RTCC_FEB: begin
                    month_len = leap ? `RTCC_DAYS_29 : `RTCC_DAYS_28;
                end
                `RTCC_APR, `RTCC_JUN, `RTCC_SEP, `RTCC_NOV: begin
                    month_len = `RTCC_DAYS_30;
                end
                default: begin
                    month_len = `RTCC_DAYS_31;
                end
            endcase
        end
    endfunction

    // Clock page counters
    reg [7:0] min_q;
    reg [7:0] hour_q;
    reg [7:0] wday_q;
    reg [7:0] mday_q;
    reg [7:0] month_q;
    // Alarm page storage and format select
    reg [7:0] al_min_q;
    reg [7:0] al_hour_q;
    reg [7:0] al_wday_q;
    reg [7:0] al_mday_q;
    reg format_q;
    // Control state
    reg page_q;
    reg run_q;
    reg leap_q;
    reg [PRESCALE_W-1:0] presc_q;

    reg [7:0] min_d;
    reg [7:0] hour_d;
    reg [7:0] wday_d;
    reg [7:0] mday_d;
    reg [7:0] month_d;
    reg [7:0] h12_next;
    reg day_carry;
    reg [31:0] rdata_d;

    wire req = wb_cyc_i & wb_stb_i;
    // Write lands on the edge where the master sees ack
    wire wr_en = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire tick = run_q &
        (presc_q == MINUTE_CYCLES[PRESCALE_W-1:0] - 1'b1);

    // Minute prescaler, held at zero while stopped so restart is clean
    always @(posedge clock) begin
        if (!rstn || !run_q || tick) begin
            presc_q <= {PRESCALE_W{1'b0}};
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // Carry chain of the running clock
    always @* begin
        min_d = min_q;
        hour_d = hour_q;
        wday_d = wday_q;
        mday_d = mday_q;
        month_d = month_q;
        day_carry = 1'b0;
        h12_next = bcd_inc(hour_q & `RTCC_MASK_HOUR12, `RTCC_H12_LAST,
            `RTCC_BCD_ZERO);
        if (tick) begin
            min_d = bcd_inc(min_q, `RTCC_MIN_LAST, `RTCC_BCD_ZERO);
            if (min_q == `RTCC_MIN_LAST) begin
                if (format_q) begin
                    // 24-hour wrap at 23
                    hour_d = bcd_inc(hour_q, `RTCC_H24_LAST,
                        `RTCC_BCD_ZERO);
                    day_carry = (hour_q == `RTCC_H24_LAST);
                end else begin
                    // 11 AM goes to 0 PM, 11 PM to 0 AM and a new day
                    hour_d = h12_next;
                    if ((hour_q & `RTCC_MASK_HOUR12) == `RTCC_H12_LAST) begin
                        hour_d[`RTCC_BIT_PM] = ~hour_q[`RTCC_BIT_PM];
                        day_carry = hour_q[`RTCC_BIT_PM];
                    end else begin
                        hour_d[`RTCC_BIT_PM] = hour_q[`RTCC_BIT_PM];
                    end
                end
            end
            if (day_carry) begin
                wday_d = bcd_inc(wday_q, `RTCC_WDAY_LAST,
                    `RTCC_BCD_ZERO);
                mday_d = bcd_inc(mday_q, month_len(month_q, leap_q),
                    `RTCC_BCD_ONE);
                if (mday_q == month_len(month_q, leap_q)) begin
                    month_d = bcd_inc(month_q, `RTCC_MONTH_LAST,
                        `RTCC_BCD_ONE);
                end
            end
        end
    end

    // Clock page: a bus write in the tick cycle wins over the count
    always @(posedge clock) begin
        if (!rstn) begin
            // Fields are undefined to software; cleared for a known start
            min_q <= `RTCC_RST_BYTE;
            hour_q <= `RTCC_RST_BYTE;
            wday_q <= `RTCC_RST_BYTE;
            mday_q <= `RTCC_RST_BYTE;
            month_q <= `RTCC_RST_BYTE;
        end else begin
            min_q <= min_d;
            hour_q <= hour_d;
            wday_q <= wday_d;
            mday_q <= mday_d;
            month_q <= month_d;
            if (wr_en && !page_q) begin
                case (wb_adr_i)
                    `RTCC_OFF_MINUTE: begin
                        min_q <= wbyte & `RTCC_MASK_MINUTE;
                    end
                    `RTCC_OFF_HOUR: begin
                        hour_q <= wbyte & `RTCC_MASK_HOUR;
                    end
                    `RTCC_OFF_WEEKDAY: begin
                        wday_q <= wbyte & `RTCC_MASK_WEEKDAY;
                    end
                    `RTCC_OFF_MDAY: begin
                        mday_q <= wbyte & `RTCC_MASK_MDAY;
                    end
                    `RTCC_OFF_MONTH: begin
                        month_q <= wbyte & `RTCC_MASK_MONTH;
                    end
                    default: begin
                        min_q <= min_d;
                    end
                endcase
            end
        end
    end

    // Alarm page and format select; only stored, never counted
    always @(posedge clock) begin
        if (!rstn) begin
            al_min_q <= `RTCC_RST_BYTE;
            al_hour_q <= `RTCC_RST_BYTE;
            al_wday_q <= `RTCC_RST_BYTE;
            al_mday_q <= `RTCC_RST_BYTE;
            format_q <= 1'b0;
        end else if (wr_en && page_q) begin
            case (wb_adr_i)
                `RTCC_OFF_MINUTE: begin
                    al_min_q <= wbyte & `RTCC_MASK_MINUTE;
                end
                `RTCC_OFF_HOUR: begin
                    al_hour_q <= wbyte & `RTCC_MASK_HOUR;
                end
                `RTCC_OFF_WEEKDAY: begin
                    al_wday_q <= wbyte & `RTCC_MASK_WEEKDAY;
                end
                `RTCC_OFF_MDAY: begin
                    al_mday_q <= wbyte & `RTCC_MASK_MDAY;
                end
                `RTCC_OFF_MONTH: begin
                    // Changing this while running skews the hour count
                    format_q <= wbyte[`RTCC_BIT_FORMAT];
                end
                default: begin
                    format_q <= format_q;
                end
            endcase
        end
    end

    // Page select and run control, shared by both pages
    always @(posedge clock) begin
        if (!rstn) begin
            // Stopped after reset, so software can load the time first
            page_q <= `RTCC_RST_PAGE;
            run_q <= 1'b0;
            leap_q <= 1'b0;
        end else if (wr_en) begin
            if (wb_adr_i == `RTCC_OFF_PAGE) begin
                page_q <= wbyte[`RTCC_BIT_PAGE];
            end
            if (wb_adr_i == `RTCC_OFF_CTRL) begin
                run_q <= wbyte[`RTCC_BIT_RUN];
                leap_q <= wbyte[`RTCC_BIT_LEAP];
            end
        end
    end

    // Read mux; unused upper bits and unmapped words read zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            `RTCC_OFF_MINUTE: begin
                rdata_d[7:0] = (page_q ? al_min_q : min_q)
                    & `RTCC_MASK_MINUTE;
            end
            `RTCC_OFF_HOUR: begin
                rdata_d[7:0] = (page_q ? al_hour_q : hour_q)
                    & `RTCC_MASK_HOUR;
            end
            `RTCC_OFF_WEEKDAY: begin
                rdata_d[7:0] = (page_q ? al_wday_q : wday_q)
                    & `RTCC_MASK_WEEKDAY;
            end
            `RTCC_OFF_MDAY: begin
                rdata_d[7:0] = (page_q ? al_mday_q : mday_q)
                    & `RTCC_MASK_MDAY;
            end
            `RTCC_OFF_MONTH: begin
                rdata_d[7:0] = page_q ? {7'h00, format_q}
                    : (month_q & `RTCC_MASK_MONTH);
            end
            `RTCC_OFF_PAGE: begin
                rdata_d[`RTCC_BIT_PAGE] = page_q;
            end
            `RTCC_OFF_CTRL: begin
                rdata_d[`RTCC_BIT_RUN] = run_q;
                rdata_d[`RTCC_BIT_LEAP] = leap_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // One-wait-state slave: ack one cycle after the request, then drop.
    // Data is captured then, so a read never mixes two counter states
    // inside one field; across fields software must double-read.
    always @(posedge clock) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= rdata_d;
            end
        end
    end

endmodule
`default_nettype wire

// *** verification/rtcc_assertions.sv ***
// Concurrent checks on the calendar register block ports
`timescale 1ns/1ns
`default_nettype none
module rtcc_assertions (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    wire rd_ack;
    // Read answer, address still held by the master
    assign rd_ack = wb_ack_o && !wb_we_i;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_minute_top: assert property (rd_ack && wb_adr_i == 8'h00
        |-> !wb_dat_o[7]) else $error("minute bit 7 set");
    a_hour_top: assert property (rd_ack && wb_adr_i == 8'h04
        |-> wb_dat_o[7:6] == 2'b00) else $error("hour top bits set");
    a_wday_top: assert property (rd_ack && wb_adr_i == 8'h08
        |-> wb_dat_o[7:3] == 5'h00) else $error("weekday top bits set");
    a_mday_top: assert property (rd_ack && wb_adr_i == 8'h0c
        |-> wb_dat_o[7:6] == 2'b00) else $error("day top bits set");
    a_month_top: assert property (rd_ack && wb_adr_i == 8'h10
        |-> wb_dat_o[7:5] == 3'h0) else $error("month top bits set");
    a_page_top: assert property (rd_ack && wb_adr_i == 8'h14
        |-> wb_dat_o[7:1] == 7'h00) else $error("page top bits set");
    a_unmapped_zero: assert property (rd_ack && wb_adr_i > 8'h18
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // Main scenarios reached
    c_alarm_page: cover property (rd_ack && wb_adr_i == 8'h14 && wb_dat_o[0]);
    c_run_write: cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h18);
    c_month_read: cover property (rd_ack && wb_adr_i == 8'h10);
endmodule
bind rtcc_regs rtcc_assertions u_chk (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench of the calendar register block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'h0;
    reg [31:0] dat = 32'h0;
    reg [31:0] q;
    reg [7:0] d;
    wire [31:0] rdata;
    wire ack;
    integer miscompares = 0;
    integer checked = 0;
    integer i;
    integer p;
    // Implemented bits per field, clock page then alarm page
    localparam [79:0] MSK = {40'h7f3f073f1f, 40'h7f3f073f01};
    rtcc_regs #(.MINUTE_CYCLES(8), .PRESCALE_W(30)) dut (
        .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdata), .wb_ack_o(ack)
    );
    // 100 ns period
    initial begin
        forever #50 clock = ~clock;
    end
    task chk(input [31:0] g, input [31:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    // One classic cycle; ack and read data taken at the same rising edge
    task acc(input w, input [7:0] a, input [7:0] v, input [3:0] s,
        output [31:0] r);
        begin
            @(posedge clock);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= {24'h0, v};
            sel <= s;
            // Wait as long as the slave needs; the watchdog ends a hang
            @(posedge clock);
            while (ack !== 1'b1) begin
                @(posedge clock);
            end
            r = rdata;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        acc(1'b1, a, v, 4'h1, q);
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        begin
            acc(1'b0, a, 8'h00, 4'hf, q);
            chk(q, {24'h0, e});
        end
    endtask
    // Time fields read twice; only an agreeing pair is accepted
    task rd2(input [7:0] a, input [7:0] e);
        reg [31:0] r0;
        begin
            acc(1'b0, a, 8'h00, 4'hf, r0);
            acc(1'b0, a, 8'h00, 4'hf, q);
            chk(q, r0);
            chk(q, {24'h0, e});
        end
    endtask
    // Load a time, run for exactly one minute tick, then compare
    task run_case(input [39:0] s, input [39:0] e, input [7:0] f,
        input [7:0] c);
        integer k;
        begin
            wr(8'h14, 8'h01);
            wr(8'h10, f);
            wr(8'h14, 8'h00);
            for (k = 0; k < 5; k = k + 1) begin
                wr(8'(4 * k), s[39 - 8 * k -: 8]);
            end
            wr(8'h18, c);
            // Tick due after 8 clocks; the stop lands before a second one
            repeat (10) @(posedge clock);
            wr(8'h18, 8'h00);
            for (k = 0; k < 5; k = k + 1) begin
                rd2(8'(4 * k), e[39 - 8 * k -: 8]);
            end
            $display("count case done");
        end
    endtask
    task end_of_test;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        rdc(8'h14, 8'h00);
        for (p = 0; p < 2; p = p + 1) begin
            d = p ? 8'hd5 : 8'hff;
            wr(8'h14, 8'(p));
            for (i = 0; i < 5; i = i + 1) begin
                wr(8'(4 * i), d);
                rdc(8'(4 * i), d & MSK[79 - 40 * p - 8 * i -: 8]);
            end
            rdc(8'h14, 8'(p));
        end
        wr(8'h14, 8'h00);
        rdc(8'h00, 8'h7f);
        rdc(8'h10, 8'h1f);
        acc(1'b1, 8'h00, 8'h00, 4'h0, q);
        rdc(8'h00, 8'h7f);
        wr(8'h1c, 8'hff);
        rdc(8'h1c, 8'h00);
        $display("map test done");
        run_case(40'h5923062802, 40'h0000000103, 8'h01, 8'h01);
        run_case(40'h5923022802, 40'h0000032902, 8'h01, 8'h03);
        run_case(40'h5931033112, 40'h0000040101, 8'h00, 8'h01);
        run_case(40'h5911043004, 40'h0020043004, 8'h00, 8'h01);
        run_case(40'h5923053004, 40'h0000060105, 8'h01, 8'h01);
        end_of_test;
    end
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares = miscompares + 1;
        end_of_test;
    end
endmodule
`default_nettype wire
